// ===== rtl/mrsf_defines.svh
`ifndef MRSF_DEFINES_SVH
`define MRSF_DEFINES_SVH

// ==========================================
// Geometry
`define MRSF_NCH        6
`define MRSF_NMON       7
`define MRSF_POS_W      3
`define MRSF_CODE_W     8
`define MRSF_LAST_POS   3'h5
`define MRSF_FIRST_POS  3'h0
`define MRSF_DVM_CH     0

// ==========================================
// Margin and dynamic voltage limits
`define MRSF_MARGIN_MAX 4'ha
`define MRSF_DIV100_MUL 6'h29
`define MRSF_DIV100_SH  12
`define MRSF_MRG_UP     2'h1
`define MRSF_MRG_DN     2'h2
`define MRSF_DVM_MAX    3'h6

// ==========================================
// Timing
`define MRSF_CLK_MHZ     10
`define MRSF_DEBOUNCE_US 10000

`endif

// ===== rtl/mrsf_pkg.sv
package mrsf_pkg;

	typedef enum logic [3:0]
	{
		MRSF_OFF  = 4'h1,
		MRSF_UP   = 4'h2,
		MRSF_ON   = 4'h4,
		MRSF_DOWN = 4'h8
	} mrsf_state_e;

endpackage

// ===== rtl/mrsf_ramp.sv
`timescale 1ns/1ps
`include "mrsf_defines.svh"

module mrsf_ramp
(
	input  wire logic                      mclk_in,
	input  wire logic                      resetn_in,
	input  wire logic                      enable_in,
	input  wire logic [`MRSF_CODE_W-1:0]   target_in,
	input  wire logic [`MRSF_CODE_W-1:0]   slew_in,
	output logic      [`MRSF_CODE_W-1:0]   level_out,
	output logic                           done_out
);

	logic [`MRSF_CODE_W-1:0] level_r;
	logic [`MRSF_CODE_W-1:0] level_nxt;
	logic [`MRSF_CODE_W-1:0] tick_r;
	logic [`MRSF_CODE_W-1:0] tick_nxt;
	logic                    tick_hit;
	logic                    below;
	logic                    above;

	// ==========================================
	// Slew limit: one code step per slew_in+1 clocks
	assign tick_hit  = (tick_r == slew_in);
	assign below     = (level_r < target_in);
	assign above     = (level_r > target_in);
	assign tick_nxt  = (!enable_in || tick_hit) ? '0 : tick_r + 8'h01;
	assign level_nxt = !enable_in ? '0 :
		(tick_hit && below) ? level_r + 8'h01 :
		(tick_hit && above) ? level_r - 8'h01 : level_r;

	always_ff @(posedge mclk_in)
	begin
		if (!resetn_in)
		begin
			level_r <= '0;
			tick_r  <= '0;
		end
		else
		begin
			level_r <= level_nxt;
			tick_r  <= tick_nxt;
		end
	end

	assign level_out = level_r;
	assign done_out  = enable_in && !below && !above;

endmodule

// ===== rtl/mrsf_ctrl.sv
`timescale 1ns/1ps
`include "mrsf_defines.svh"

module mrsf_ctrl
#(
	parameter int DEBOUNCE_CYC = `MRSF_DEBOUNCE_US * `MRSF_CLK_MHZ
)
(
	input  wire logic                          mclk_in,
	input  wire logic                          resetn_in,
	input  wire logic [`MRSF_NCH*3-1:0]        seq_pos_in,
	input  wire logic                          power_on_cmd_in,
	input  wire logic                          power_off_cmd_in,
	input  wire logic [`MRSF_NCH-1:0]          chan_on_cmd_in,
	input  wire logic [`MRSF_NCH-1:0]          chan_off_cmd_in,
	input  wire logic                          channel_enable_input_in,
	input  wire logic                          enable_button_mode_in,
	input  wire logic [`MRSF_NCH-1:0]          enable_chan_sel_in,
	input  wire logic [`MRSF_NCH-1:0]          uv_cmp_in,
	input  wire logic [`MRSF_NCH-1:0]          ov_cmp_in,
	input  wire logic                          batt_uv_cmp_in,
	input  wire logic                          batt_ov_cmp_in,
	input  wire logic                          input_warn_cmp_in,
	input  wire logic                          input_fault_cmp_in,
	input  wire logic                          input_lockout_in,
	input  wire logic [`MRSF_NMON-1:0]         fault_trig_en_in,
	input  wire logic [`MRSF_NMON-1:0]         fault_force_off_in,
	input  wire logic                          alert_clear_in,
	input  wire logic                          warn_clear_in,
	input  wire logic [`MRSF_NCH*8-1:0]        nominal_code_in,
	input  wire logic [`MRSF_NCH*2-1:0]        margin_sel_in,
	input  wire logic [3:0]                    margin_pct_in,
	input  wire logic [2:0]                    dvm_level_in,
	input  wire logic [7:0]                    dvm_step_in,
	input  wire logic [7:0]                    slew_in,
	output logic      [`MRSF_NCH-1:0]          chan_enable_out,
	output logic      [`MRSF_NCH*8-1:0]        setpoint_out,
	output logic                               input_low_warn_out,
	output logic                               battery_fault_n_out,
	output logic                               fault_alert_n_out,
	output logic                               outputs_within_limits_out,
	output logic      [3:0]                    seq_state_out
);

	// ==========================================
	// Pin synchronisers (comparators and pins are asynchronous)
	localparam int SW = 2 * `MRSF_NCH + 6;
	logic [SW-1:0] sync1_r;
	logic [SW-1:0] sync2_r;

	always_ff @(posedge mclk_in)
	begin
		if (!resetn_in)
		begin
			sync1_r <= '0;
			sync2_r <= '0;
		end
		else
		begin
			sync1_r <= {uv_cmp_in, ov_cmp_in, batt_uv_cmp_in, batt_ov_cmp_in,
				input_warn_cmp_in, input_fault_cmp_in, input_lockout_in,
				channel_enable_input_in};
			sync2_r <= sync1_r;
		end
	end

	wire [`MRSF_NCH-1:0] uv_s     = sync2_r[SW-1 -: `MRSF_NCH];
	wire [`MRSF_NCH-1:0] ov_s     = sync2_r[`MRSF_NCH+5 -: `MRSF_NCH];
	wire                 buv_s    = sync2_r[5];
	wire                 bov_s    = sync2_r[4];
	wire                 warn_s   = sync2_r[3];
	wire                 bfault_s = sync2_r[2];
	wire                 lock_s   = sync2_r[1];
	wire                 pin_s    = sync2_r[0];

	// ==========================================
	// State
	mrsf_pkg::mrsf_state_e  state_r;
	mrsf_pkg::mrsf_state_e  state_nxt;
	logic [2:0]             pos_r;
	logic [2:0]             pos_nxt;
	logic [`MRSF_NCH-1:0]   seq_en_r;
	logic [`MRSF_NCH-1:0]   seq_en_nxt;
	logic [`MRSF_NCH-1:0]   man_en_r;
	logic                   fault_r;
	logic                   warn_r;
	logic                   bfault_n_r;
	logic                   within_r;
	logic                   btn_r;
	logic                   block_r;
	logic                   btn_stable_r;
	logic [16:0]            deb_cnt_r;

	// ==========================================
	// Per-channel decode, targets and soft-start ramps
	logic [`MRSF_NCH-1:0]   at_pos;
	logic [`MRSF_NCH-1:0]   ramp_done;
	logic [`MRSF_NCH-1:0]   chan_en;

	// Margin clamped to ten percent, dvm level clamped to seven settings
	wire [3:0] mpct = (margin_pct_in > `MRSF_MARGIN_MAX) ?
		`MRSF_MARGIN_MAX : margin_pct_in;
	wire [2:0] dvm_lvl = (dvm_level_in > `MRSF_DVM_MAX) ?
		`MRSF_DVM_MAX : dvm_level_in;
	wire [10:0] dvm_prod = dvm_step_in * dvm_lvl;
	wire [7:0] dvm_drop = (dvm_prod[10:8] != 3'h0) ? 8'hff : dvm_prod[7:0];

	genvar g;
	generate
		for (g = 0; g < `MRSF_NCH; g++)
		begin : gen_ch
			wire [2:0]  my_pos = seq_pos_in[g*3 +: 3];
			wire [7:0]  nom    = nominal_code_in[g*8 +: 8];
			wire [1:0]  msel   = margin_sel_in[g*2 +: 2];
			wire [17:0] prod   = nom * mpct * `MRSF_DIV100_MUL;
			wire [7:0]  delta  = prod[`MRSF_DIV100_SH +: 8];
			wire [8:0]  up_sum = {1'b0, nom} + {1'b0, delta};
			wire [7:0]  mrg    = (msel == `MRSF_MRG_UP) ?
				(up_sum[8] ? 8'hff : up_sum[7:0]) :
				(msel == `MRSF_MRG_DN) ? nom - delta : nom;
			wire [7:0]  tgt    = (g == `MRSF_DVM_CH) ?
				((mrg > dvm_drop) ? mrg - dvm_drop : 8'h00) : mrg;

			assign at_pos[g] = (my_pos == pos_r);

			mrsf_ramp u_ramp
			(
				.mclk_in   (mclk_in),
				.resetn_in (resetn_in),
				.enable_in (chan_en[g]),
				.target_in (tgt),
				.slew_in   (slew_in),
				.level_out (setpoint_out[g*8 +: 8]),
				.done_out  (ramp_done[g])
			);
		end
	endgenerate

	// Channels sitting at the following position
	logic [`MRSF_NCH-1:0] at_pos_next;
	generate
		for (g = 0; g < `MRSF_NCH; g++)
		begin : gen_nxt
			assign at_pos_next[g] = (seq_pos_in[g*3 +: 3] == pos_r + 3'h1);
		end
	endgenerate

	// ==========================================
	// Enable pin: level or debounced push button
	// Press only counts in button mode, else a level drop would start the cascade
	wire btn_press = enable_button_mode_in && btn_stable_r && !pin_s &&
		(deb_cnt_r == 17'(DEBOUNCE_CYC));
	wire en_req    = enable_button_mode_in ? btn_r : pin_s;
	wire [`MRSF_NCH-1:0] pin_en =
		enable_chan_sel_in & {`MRSF_NCH{en_req && !block_r}};

	// ==========================================
	// Fault detection
	// UV on an output only counts once its ramp reached target
	wire [`MRSF_NCH-1:0] out_uv = uv_s & chan_en & ramp_done;
	wire [`MRSF_NCH-1:0] out_ov = ov_s & chan_en;
	wire [`MRSF_NMON-1:0] mon_hit = {buv_s | bov_s, out_uv | out_ov};
	wire [`MRSF_NMON-1:0] trig    = mon_hit & fault_trig_en_in;
	wire fault_any  = |trig;
	wire fault_kill = |(trig & fault_force_off_in);

	wire [`MRSF_NCH-1:0] valid_mask = ~chan_en | (~uv_s & ~ov_s);
	wire seq_valid = &(valid_mask | ~seq_en_r);
	// Wait until the position is off and its rails really fell
	wire down_done = !(|(seq_en_r & at_pos)) &&
		&(uv_s | ~at_pos | man_en_r | pin_en);
	wire start_req = (power_on_cmd_in || btn_press) && !lock_s && !fault_r;

	// Lockout drops everything immediately; software off clears the enable registers on the next clock
	assign chan_en = (seq_en_r | man_en_r | pin_en) & {`MRSF_NCH{!lock_s}};

	// ==========================================
	// Sequencer
	always_comb
	begin
		state_nxt  = state_r;
		pos_nxt    = pos_r;
		seq_en_nxt = seq_en_r;
		case (state_r)
			mrsf_pkg::MRSF_OFF:
			begin
				if (start_req)
				begin
					state_nxt  = mrsf_pkg::MRSF_UP;
					pos_nxt    = `MRSF_FIRST_POS;
					seq_en_nxt = at_pos;
				end
			end
			mrsf_pkg::MRSF_UP:
			begin
				if (seq_valid)
				begin
					if (pos_r == `MRSF_LAST_POS)
						state_nxt = mrsf_pkg::MRSF_ON;
					else
					begin
						pos_nxt = pos_r + 3'h1;
						seq_en_nxt = seq_en_r | at_pos_next;
					end
				end
			end
			mrsf_pkg::MRSF_ON:
			begin
				state_nxt = mrsf_pkg::MRSF_ON;
			end
			mrsf_pkg::MRSF_DOWN:
			begin
				seq_en_nxt = seq_en_r & ~at_pos;
				if (down_done)
				begin
					if (pos_r == `MRSF_FIRST_POS)
						state_nxt = mrsf_pkg::MRSF_OFF;
					else
						pos_nxt = pos_r - 3'h1;
				end
			end
			default:
			begin
				state_nxt = mrsf_pkg::MRSF_OFF;
			end
		endcase
		if (power_off_cmd_in || lock_s || fault_kill)
		begin
			state_nxt  = mrsf_pkg::MRSF_OFF;
			seq_en_nxt = '0;
			pos_nxt    = `MRSF_FIRST_POS;
		end
		else if (fault_any && (state_r != mrsf_pkg::MRSF_DOWN) &&
			(state_r != mrsf_pkg::MRSF_OFF))
		begin
			state_nxt = mrsf_pkg::MRSF_DOWN;
			pos_nxt   = `MRSF_LAST_POS;
		end
	end

	always_ff @(posedge mclk_in)
	begin
		if (!resetn_in)
		begin
			state_r  <= mrsf_pkg::MRSF_OFF;
			pos_r    <= `MRSF_FIRST_POS;
			seq_en_r <= '0;
		end
		else
		begin
			state_r  <= state_nxt;
			pos_r    <= pos_nxt;
			seq_en_r <= seq_en_nxt & ~chan_off_cmd_in;
		end
	end

	// ==========================================
	// Individual on/off; off wins over on in one cycle
	always_ff @(posedge mclk_in)
	begin
		if (!resetn_in)
			man_en_r <= '0;
		else if (power_off_cmd_in || fault_kill)
			man_en_r <= '0;
		else
			man_en_r <= (man_en_r | chan_on_cmd_in) & ~chan_off_cmd_in;
	end

	// ==========================================
	// Push button debounce and software override
	always_ff @(posedge mclk_in)
	begin
		if (!resetn_in)
		begin
			btn_stable_r <= 1'b1;
			deb_cnt_r    <= '0;
			btn_r        <= 1'b0;
			block_r      <= 1'b0;
		end
		else
		begin
			if (pin_s != btn_stable_r)
				deb_cnt_r <= '0;
			else if (deb_cnt_r != 17'(DEBOUNCE_CYC))
				deb_cnt_r <= deb_cnt_r + 17'h1;
			if (deb_cnt_r == 17'(DEBOUNCE_CYC))
				btn_stable_r <= !pin_s ? 1'b0 : 1'b1;
			if (power_off_cmd_in)
				btn_r <= 1'b0;
			else if (btn_press && btn_stable_r)
				btn_r <= !btn_r;
			if (power_off_cmd_in)
				block_r <= 1'b1;
			else if (!en_req)
				block_r <= 1'b0;
		end
	end

	// ==========================================
	// Status flags; a new event beats a same-cycle clear
	always_ff @(posedge mclk_in)
	begin
		if (!resetn_in)
		begin
			fault_r    <= 1'b0;
			warn_r     <= 1'b0;
			bfault_n_r <= 1'b1;
			within_r   <= 1'b0;
		end
		else
		begin
			fault_r    <= (fault_any || bfault_s) || (fault_r && !alert_clear_in);
			warn_r     <= warn_s || (warn_r && !warn_clear_in);
			bfault_n_r <= !bfault_s;
			within_r   <= &valid_mask;
		end
	end

	assign chan_enable_out           = chan_en;
	assign input_low_warn_out        = warn_r;
	assign battery_fault_n_out       = bfault_n_r;
	assign fault_alert_n_out         = !fault_r;
	assign outputs_within_limits_out = within_r;
	assign seq_state_out             = state_r;

endmodule

// ===== tb/mrsf_ctrl_sva.sv
`timescale 1ns/1ps
module mrsf_ctrl_sva
(
	input wire logic	mclk_in,
	input wire logic	resetn_in,
	input wire logic	power_on_cmd_in,
	input wire logic	power_off_cmd_in,
	input wire logic [5:0]	chan_off_cmd_in,
	input wire logic	input_warn_cmp_in,
	input wire logic	input_fault_cmp_in,
	input wire logic	input_lockout_in,
	input wire logic	warn_clear_in,
	input wire logic	alert_clear_in,
	input wire logic [5:0]	chan_enable_out,
	input wire logic [47:0]	setpoint_out,
	input wire logic	input_low_warn_out,
	input wire logic	battery_fault_n_out,
	input wire logic	fault_alert_n_out,
	input wire logic [3:0]	seq_state_out
);
	default clocking @(posedge mclk_in); endclocking
	default disable iff (!resetn_in);
	// ====
	// Pins take two sync stages plus one register
	warn_set_a: assert property (input_warn_cmp_in [*3] |=> input_low_warn_out)
		else $error("warning not raised");
	warn_hold_a: assert property (input_low_warn_out && !warn_clear_in |=> input_low_warn_out)
		else $error("warning dropped");
	batt_fault_a: assert property (input_fault_cmp_in [*3] |=> !battery_fault_n_out)
		else $error("battery fault missing");
	alert_hold_a: assert property (!fault_alert_n_out && !alert_clear_in |=> !fault_alert_n_out)
		else $error("alert dropped");
	lockout_off_a: assert property (input_lockout_in [*3] |=> chan_enable_out == 6'h00)
		else $error("enable under lockout");
	power_off_a: assert property (power_off_cmd_in |=> chan_enable_out == 6'h00 && seq_state_out == 4'h1)
		else $error("power off ignored");
	start_block_a: assert property (power_on_cmd_in && !fault_alert_n_out && seq_state_out == 4'h1 |=> seq_state_out == 4'h1)
		else $error("start with alert latched");
	chan_off_a: assert property (chan_off_cmd_in[3] |=> !chan_enable_out[3])
		else $error("channel off ignored");
	sp_zero_a: assert property (!chan_enable_out[0] |=> setpoint_out[7:0] == 8'h00)
		else $error("setpoint while disabled");
	state_hot_a: assert property ($onehot(seq_state_out))
		else $error("state not one-hot");
endmodule
bind mrsf_ctrl mrsf_ctrl_sva i_mrsf_ctrl_sva (.mclk_in, .resetn_in, .power_on_cmd_in,
	.power_off_cmd_in, .chan_off_cmd_in, .input_warn_cmp_in, .input_fault_cmp_in,
	.input_lockout_in, .warn_clear_in, .alert_clear_in, .chan_enable_out, .setpoint_out,
	.input_low_warn_out, .battery_fault_n_out, .fault_alert_n_out, .seq_state_out);

// ===== tb/mrsf_rails_model.sv
`timescale 1ns/1ps
module mrsf_rails_model
#(
	parameter int BASE_DLY = 3
)
(
	input wire logic	mclk_in,
	input wire logic [5:0]	en_in,
	input wire logic [5:0]	ov_inj_in,
	output logic [5:0]	uv_out,
	output logic [5:0]	ov_out
);
	logic [5:0]	good_r = 6'h00;
	int	cnt_r[6] = '{default: 0};
	// ====
	// Rails settle or discharge after a per-channel delay, later channels slower
	always_ff @(posedge mclk_in)
	begin
		for (int g = 0; g < 6; g++)
		begin
			if (en_in[g] == good_r[g])
				cnt_r[g] <= 0;
			else if (cnt_r[g] >= BASE_DLY + 2 * g)
				good_r[g] <= en_in[g];
			else
				cnt_r[g] <= cnt_r[g] + 1;
		end
	end
	assign uv_out = ~good_r;
	assign ov_out = ov_inj_in;
endmodule

// ===== tb/tb.sv
`timescale 1ns/1ps
module tb;
	logic	mclk_in, resetn_in, power_on_cmd_in, power_off_cmd_in, alert_clear_in, warn_clear_in;
	logic	input_warn_cmp_in, input_fault_cmp_in, input_lockout_in, input_low_warn_out;
	logic	battery_fault_n_out, fault_alert_n_out, outputs_within_limits_out;
	logic	pin_in, btn_mode, batt_uv, batt_ov;
	logic [5:0]	en_sel;
	logic [17:0]	seq_pos_in;
	logic [5:0]	chan_on_cmd_in, chan_off_cmd_in, uv_cmp_in, ov_cmp_in, ov_inj, chan_enable_out;
	logic [6:0]	fault_trig_en_in, fault_force_off_in;
	logic [47:0]	nominal_code_in, setpoint_out;
	logic [11:0]	margin_sel_in;
	logic [3:0]	margin_pct_in, seq_state_out;
	logic [2:0]	dvm_level_in;
	logic [7:0]	dvm_step_in, slew_in;
	logic [31:0]	rnd;
	logic [3:0]	st_q[$];
	logic [2:0]	fl_q[$];
	logic [48:0]	sp_q[$];
	event	sp_ev;
	int	miscompares = 0;
	int	n_checks = 0;
	// ====
	// Design, rails and clock
	mrsf_ctrl #(.DEBOUNCE_CYC(8)) i_mrsf_ctrl (.mclk_in, .resetn_in, .seq_pos_in, .power_on_cmd_in,
		.power_off_cmd_in, .chan_on_cmd_in, .chan_off_cmd_in, .channel_enable_input_in(pin_in),
		.enable_button_mode_in(btn_mode), .enable_chan_sel_in(en_sel), .uv_cmp_in, .ov_cmp_in,
		.batt_uv_cmp_in(batt_uv), .batt_ov_cmp_in(batt_ov), .input_warn_cmp_in, .input_fault_cmp_in,
		.input_lockout_in, .fault_trig_en_in, .fault_force_off_in, .alert_clear_in,
		.warn_clear_in, .nominal_code_in, .margin_sel_in, .margin_pct_in, .dvm_level_in,
		.dvm_step_in, .slew_in, .chan_enable_out, .setpoint_out, .input_low_warn_out,
		.battery_fault_n_out, .fault_alert_n_out, .outputs_within_limits_out, .seq_state_out);
	mrsf_rails_model i_mrsf_rails_model (.mclk_in, .en_in(chan_enable_out), .ov_inj_in(ov_inj),
		.uv_out(uv_cmp_in), .ov_out(ov_cmp_in));
	initial
	begin
		mclk_in = 1'b0;
		forever #50 mclk_in = ~mclk_in;
	end
	// ====
	// Helpers
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	function automatic logic [48:0] exp_sp(input logic [5:0] on);
		logic [48:0] r;
		int nom, v;
		int pct;
		int lvl;
		r = {1'b1, 48'h0};
		pct = (margin_pct_in > 4'ha) ? 10 : int'(margin_pct_in);
		lvl = (dvm_level_in > 3'h6) ? 6 : int'(dvm_level_in);
		for (int g = 0; g < 6; g++)
		begin
			nom = int'(nominal_code_in[8*g+:8]);
			v = (nom * pct * 41) >> 12;
			v = (margin_sel_in[2*g+:2] == 2'h1) ? nom + v : (margin_sel_in[2*g+:2] == 2'h2) ? nom - v : nom;
			if (g == 0)
				v = (v > lvl * dvm_step_in) ? v - lvl * dvm_step_in : 0;
			if (on[g])
				r[8*g+:8] = v[7:0];
		end
		return r;
	endfunction
	task automatic tick(input int n);
		repeat (n) @(posedge mclk_in);
	endtask
	task automatic mism(input logic [48:0] e, input logic [48:0] a);
		miscompares++;
		$display("CHECK FAILED t=%0t exp=%h got=%h", $time, e, a);
	endtask
	task automatic cmp_st(input logic [3:0] e, input logic [3:0] a);
		n_checks++;
		if (e !== a)
			mism(49'(e), 49'(a));
	endtask
	task automatic cmp_fl(input logic [2:0] e, input logic [2:0] a);
		n_checks++;
		if (e !== a)
			mism(49'(e), 49'(a));
	endtask
	task automatic cmp_sp(input logic [48:0] e, input logic [48:0] a);
		n_checks++;
		if (e !== a)
			mism(e, a);
	endtask
	// Kinds: 0 start, 1 power off, 2 channel 3 off, 3 clear both latches
	task automatic pulse(input int k);
		@(posedge mclk_in);
		power_on_cmd_in <= (k == 0);
		power_off_cmd_in <= (k == 1);
		chan_off_cmd_in <= (k == 2) ? 6'h08 : 6'h00;
		{alert_clear_in, warn_clear_in} <= (k == 3) ? 2'h3 : 2'h0;
		@(posedge mclk_in);
		{power_on_cmd_in, power_off_cmd_in, alert_clear_in, warn_clear_in} <= 4'h0;
		chan_off_cmd_in <= 6'h00;
	endtask
	task automatic wait_st(input logic [3:0] s);
		for (int i = 0; i < 3000 && seq_state_out !== s; i++)
			@(posedge mclk_in);
	endtask
	task automatic run_up();
		st_q.push_back(4'h2);
		st_q.push_back(4'h4);
		pulse(0);
		wait_st(4'h4);
	endtask
	task automatic print_verdict();
		$display("checks %0d miscompares %0d", n_checks, miscompares);
		if (miscompares == 0 && n_checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	// ====
	// Monitors: each change of state or flags, and each sp_ev, takes the oldest note
	initial
	begin
		@(posedge resetn_in);
		fork
			forever @(seq_state_out) cmp_st(st_q.size() ? st_q.pop_front() : 4'h0, seq_state_out);
			forever @({input_low_warn_out, battery_fault_n_out, fault_alert_n_out})
				cmp_fl(fl_q.size() ? fl_q.pop_front() : 3'h7, {input_low_warn_out, battery_fault_n_out, fault_alert_n_out});
			forever @(sp_ev) cmp_sp(sp_q.pop_front(), {outputs_within_limits_out, setpoint_out});
		join
	end
	initial
	begin
		tick(60000);
		miscompares++;
		print_verdict();
	end
	// ====
	// Main sequence
	initial
	begin
		{resetn_in, power_on_cmd_in, power_off_cmd_in, alert_clear_in, warn_clear_in} = 5'h0;
		{input_warn_cmp_in, input_fault_cmp_in, input_lockout_in} = 3'h0;
		{pin_in, btn_mode, batt_uv, batt_ov, en_sel} = 10'h0;
		{chan_on_cmd_in, chan_off_cmd_in, ov_inj, fault_force_off_in} = 25'h0;
		fault_trig_en_in = 7'h7f;
		rnd = 32'h6ce8;
		for (int g = 0; g < 6; g++)
		begin
			rnd = lfsr(rnd);
			seq_pos_in[3*g+:3] = 3'(rnd[7:0] % 6);
			nominal_code_in[8*g+:8] = {2'h1, rnd[13:8]};
			margin_sel_in[2*g+:2] = (g == 0) ? 2'h0 : 2'(rnd[17:16] % 3);
		end
		{slew_in, dvm_step_in, dvm_level_in, margin_pct_in} = {6'h0, rnd[31:30], 5'h0, rnd[29:20]};
		tick(5);
		resetn_in <= 1'b1;
		input_lockout_in <= 1'b1;
		tick(4);
		pulse(0);
		tick(6);
		input_lockout_in <= 1'b0;
		tick(4);
		run_up();
		tick(700);
		sp_q.push_back(exp_sp(6'h3f));
		->sp_ev;
		pulse(2);
		tick(20);
		sp_q.push_back(exp_sp(6'h37));
		->sp_ev;
		st_q.push_back(4'h1);
		pulse(1);
		wait_st(4'h1);
		run_up();
		st_q.push_back(4'h8);
		st_q.push_back(4'h1);
		fl_q = '{3'h2, 3'h6, 3'h4, 3'h6, 3'h3};
		ov_inj <= 6'h04;
		wait_st(4'h1);
		ov_inj <= 6'h00;
		tick(6);
		pulse(0);
		tick(6);
		input_warn_cmp_in <= 1'b1;
		tick(6);
		input_fault_cmp_in <= 1'b1;
		tick(6);
		input_fault_cmp_in <= 1'b0;
		input_warn_cmp_in <= 1'b0;
		tick(6);
		pulse(3);
		tick(6);
		fault_force_off_in <= 7'h7f;
		run_up();
		st_q.push_back(4'h1);
		fl_q = '{3'h2, 3'h3};
		ov_inj <= 6'h10;
		wait_st(4'h1);
		ov_inj <= 6'h00;
		tick(6);
		pulse(3);
		tick(6);
		pin_in <= 1'b1;
		en_sel <= 6'h02;
		tick(700);
		sp_q.push_back(exp_sp(6'h02));
		->sp_ev;
		pin_in <= 1'b0;
		chan_on_cmd_in <= 6'h20;
		tick(1);
		chan_on_cmd_in <= 6'h00;
		tick(700);
		sp_q.push_back(exp_sp(6'h20));
		->sp_ev;
		fl_q = '{3'h2, 3'h3};
		{batt_uv, batt_ov} <= 2'h3;
		tick(6);
		{batt_uv, batt_ov} <= 2'h0;
		tick(6);
		pulse(3);
		tick(6);
		st_q = '{4'h2, 4'h4, 4'h1};
		btn_mode <= 1'b1;
		pin_in <= 1'b1;
		tick(20);
		pin_in <= 1'b0;
		wait_st(4'h4);
		pin_in <= 1'b1;
		pulse(1);
		wait_st(4'h1);
		tick(6);
		if (st_q.size() + fl_q.size() != 0)
			miscompares++;
		print_verdict();
	end
endmodule
